// ### hdl/laser_tol_pkg.sv
package laser_tol_pkg;
    // command codes presented on cmd_code with cmd_valid
    typedef enum logic [3:0] {
        cmd_out_query = 4'h0,
        cmd_range_set = 4'h1,
        cmd_range_query = 4'h2,
        cmd_ldi_query = 4'h3,
        cmd_mdi_query = 4'h4,
        cmd_mdp_query = 4'h5,
        cmd_step_set = 4'h6,
        cmd_step_query = 4'h7,
        cmd_inc = 4'h8,
        cmd_dec = 4'h9,
        cmd_tol_set = 4'hA,
        cmd_tol_query = 4'hB,
        cmd_wait = 4'hC,
        cmd_opc_query = 4'hD
    } cmd_t;

    // laser control modes
    typedef enum logic [1:0] {
        mode_ilbw = 2'h0,
        mode_ihbw = 2'h1,
        mode_power = 2'h3
    } mode_t;

    // tolerance checker states, gray coded
    typedef enum logic [1:0] {
        tol_idle = 2'h0,
        tol_timing = 2'h1,
        tol_done = 2'h3
    } tol_state_t;

    localparam int value_w = 20;
    localparam int range_code_w = 4;
    localparam logic [3:0] range_code_low_reset = 4'h5;
    localparam logic [15:0] step_min = 16'h0001;
    localparam logic [15:0] step_max = 16'h270F;       // 9999
    localparam logic [15:0] step_reset = 16'h0001;
    // band in 0.1 mA units, window in ms
    localparam logic [15:0] band_min = 16'h0001;       // 0.1 mA
    localparam logic [15:0] band_max = 16'h03E8;       // 100.0 mA
    localparam logic [15:0] band_reset = 16'h0064;     // 10.0 mA
    localparam logic [15:0] window_min = 16'h0001;     // 1 ms
    localparam logic [15:0] window_max = 16'hC350;     // 50000 ms
    localparam logic [15:0] window_reset = 16'h1388;   // 5000 ms
    // power-mode band on monitor current, in uA
    localparam logic [19:0] power_band_ua = 20'h00032; // 50 uA
    // one millisecond of a 40 MHz clock
    localparam int clock_khz = 40000;
    localparam int ms_time = 1;
    localparam int cycles_per_ms = clock_khz * ms_time;
    localparam logic [9:0] error_range_busy = 10'h203; // 515
endpackage

// ### hdl/tol_window.sv
`timescale 1ns/10ps
// watches a measurement against a band for an uninterrupted window
module tol_window #(
    parameter int ms_cycles = laser_tol_pkg::cycles_per_ms
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic [19:0] target,
    input wire logic [19:0] measured,
    input wire logic [19:0] band,
    input wire logic [15:0] window_ms,
    output logic in_band,
    output logic settled
);
    logic [19:0] diff;
    logic [31:0] tick;
    logic [15:0] ms_count;
    laser_tol_pkg::tol_state_t state;

    // absolute difference, no sign handling needed downstream
    assign diff = (measured > target) ? measured - target : target - measured;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_band <= 1'b0;
        end else begin
            in_band <= (diff <= band);
        end
    end

    // window timer; leaving the band starts the count again
    always_ff @(posedge clock) begin
        if (sys_rst || restart || !in_band) begin
            tick <= 32'h00000000;
            ms_count <= 16'h0000;
            state <= laser_tol_pkg::tol_idle;
        end else begin
            unique case (state)
                laser_tol_pkg::tol_idle: begin
                    state <= laser_tol_pkg::tol_timing;
                end
                laser_tol_pkg::tol_timing: begin
                    if (tick == 32'(ms_cycles - 1)) begin
                        tick <= 32'h00000000;
                        ms_count <= ms_count + 16'h0001;
                    end else begin
                        tick <= tick + 32'h00000001;
                    end
                    if (ms_count >= window_ms) begin
                        state <= laser_tol_pkg::tol_done;
                    end
                end
                laser_tol_pkg::tol_done: begin
                    state <= laser_tol_pkg::tol_done;
                end
            endcase
        end
    end

    assign settled = (state == laser_tol_pkg::tol_done);
endmodule // tol_window

// ### hdl/laser_setpoint_tolerance_cmd.sv
`timescale 1ns/10ps
// How it works
// - output query returns the output switch state
// - range set takes the variant's range codes
// - range change while output on flags error 515
// - range query echoes the active range code
// - one current set point shared by all ranges
// - monitor current set point reported in uA
// - power set point used only when calibrated
// - step accepts 1 to 9999 and reads back
// - inc and dec move the active set point
// - one step is the mode's smallest unit
// - tolerance takes band and time window
// - complete only after window in band
// - wait and complete query held until settled
// - tolerance defaults to 10.0 mA, 5 s
// - power mode uses fixed 50 uA band
// - tolerance query returns band then window
// - calibration factor picks current or power set point
// - entering or leaving tolerance sets event flag
module laser_setpoint_tolerance_cmd #(
    parameter logic [3:0] range_code_a = 4'h5,
    parameter logic [3:0] range_code_b = 4'h1,
    parameter int ms_cycles = laser_tol_pkg::cycles_per_ms
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [19:0] cmd_arg_a,
    input wire logic [19:0] cmd_arg_b,
    input wire logic output_on,
    input wire logic [1:0] laser_mode,
    input wire logic [15:0] monitor_responsivity_alias,
    input wire logic [19:0] current_setpoint,
    input wire logic [19:0] monitor_photo_current_setpoint,
    input wire logic [19:0] monitor_photo_power_setpoint,
    input wire logic [19:0] measured_current,
    input wire logic [19:0] monitor_photo_current,
    input wire logic [19:0] monitor_photo_power,
    input wire logic event_clear,
    output logic cmd_busy,
    output logic reply_valid,
    output logic [19:0] reply_a,
    output logic [19:0] reply_b,
    output logic error_valid,
    output logic [9:0] error_code,
    output logic [3:0] range_code,
    output logic step_write,
    output logic [19:0] step_value,
    output logic settled,
    output logic tol_event
);
    // stored command parameters
    logic [15:0] step_size;
    logic [15:0] band;
    logic [15:0] window_ms;

    // hold state for wait and the completion query
    logic pending_opc;
    logic waiting;

    // history used to restart the window
    logic prev_out;
    logic [19:0] prev_target;
    logic restart;

    // tolerance path for the active mode
    logic [19:0] target;
    logic [19:0] measured;
    logic [19:0] band_eff;
    logic in_band;
    logic in_band_q;
    logic win_settled;
    logic power_mode;
    logic calibrated;

    // command decode
    laser_tol_pkg::cmd_t cmd;
    logic take;

    assign cmd = laser_tol_pkg::cmd_t'(cmd_code);
    // waiting blocks every later command; a strobe during a hold is
    // dropped rather than queued, so the host must watch cmd_busy
    assign take = cmd_valid && !waiting && !pending_opc;
    assign power_mode = (laser_mode == laser_tol_pkg::mode_power);
    assign calibrated = (monitor_responsivity_alias != 16'h0000);

    // pick the controlled quantity and band for the active mode;
    // calibrated power mode keeps the fixed band in its own units,
    // a known limitation when the factor is far from one
    always_comb begin
        target = current_setpoint;
        measured = measured_current;
        band_eff = 20'(band);
        if (power_mode) begin
            band_eff = laser_tol_pkg::power_band_ua;
            measured = monitor_photo_current;
            target = monitor_photo_current_setpoint;
            if (calibrated) begin
                measured = monitor_photo_power;
                target = monitor_photo_power_setpoint;
            end
        end
    end

    // restart the window on output-on or any change of the active mode's target;
    // holding restart while off keeps a stale window from completing
    assign restart = (output_on && !prev_out) || (target != prev_target) || !output_on;

    // one-cycle history of the switch and the target
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prev_out <= 1'b0;
            prev_target <= 20'h00000;
        end else begin
            prev_out <= output_on;
            prev_target <= target;
        end
    end

    // band and window timer for the selected quantity
    tol_window #(
        .ms_cycles(ms_cycles)
    ) u_window (
        .clock(clock),
        .sys_rst(sys_rst),
        .restart(restart),
        .target(target),
        .measured(measured),
        .band(band_eff),
        .window_ms(window_ms),
        .in_band(in_band),
        .settled(win_settled)
    );

    // registered copy so the settled port comes straight from a flop;
    // it trails the internal window state by one edge, and the hold
    // logic below uses the internal state to avoid that extra lag
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            settled <= 1'b0;
        end else begin
            settled <= win_settled;
        end
    end

    // event flag on each tolerance edge; a new edge wins over clear
    // it follows the settled window, so band ripple alone raises nothing
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_band_q <= 1'b0;
            tol_event <= 1'b0;
        end else begin
            in_band_q <= win_settled;
            if (win_settled != in_band_q) begin
                tol_event <= 1'b1;
            end else if (event_clear) begin
                tol_event <= 1'b0;
            end
        end
    end

    // range select, refused while output is on
    // codes other than the two of this variant leave the range as it was
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            range_code <= range_code_a;
            error_valid <= 1'b0;
            error_code <= 10'h000;
        end else begin
            error_valid <= 1'b0;
            if (take && cmd == laser_tol_pkg::cmd_range_set) begin
                if (output_on) begin
                    error_valid <= 1'b1;
                    error_code <= laser_tol_pkg::error_range_busy;
                end else if (cmd_arg_a[3:0] == range_code_a || cmd_arg_a[3:0] == range_code_b) begin
                    range_code <= cmd_arg_a[3:0];
                end
            end
        end
    end

    // step size and tolerance parameters, out-of-range writes ignored
    // silently; a refused write gives no error, so the host reads back
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            step_size <= laser_tol_pkg::step_reset;
            band <= laser_tol_pkg::band_reset;
            window_ms <= laser_tol_pkg::window_reset;
        end else if (take) begin
            if (cmd == laser_tol_pkg::cmd_step_set && cmd_arg_a[19:16] == 4'h0 &&
                cmd_arg_a[15:0] >= laser_tol_pkg::step_min &&
                cmd_arg_a[15:0] <= laser_tol_pkg::step_max) begin
                step_size <= cmd_arg_a[15:0];
            end
            if (cmd == laser_tol_pkg::cmd_tol_set && cmd_arg_a[19:16] == 4'h0 &&
                cmd_arg_b[19:16] == 4'h0 &&
                cmd_arg_a[15:0] >= laser_tol_pkg::band_min &&
                cmd_arg_a[15:0] <= laser_tol_pkg::band_max &&
                cmd_arg_b[15:0] >= laser_tol_pkg::window_min &&
                cmd_arg_b[15:0] <= laser_tol_pkg::window_max) begin
                band <= cmd_arg_a[15:0];
                window_ms <= cmd_arg_b[15:0];
            end
        end
    end

    // inc/dec produce the new set point in the active mode's unit
    // the stored set point is not changed here; its owner takes step_value
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            step_write <= 1'b0;
            step_value <= 20'h00000;
        end else begin
            step_write <= 1'b0;
            if (take && cmd == laser_tol_pkg::cmd_inc) begin
                step_write <= 1'b1;
                step_value <= target + 20'(step_size);
            end else if (take && cmd == laser_tol_pkg::cmd_dec) begin
                step_write <= 1'b1;
                // clamp at zero rather than wrap
                step_value <= (target > 20'(step_size)) ? target - 20'(step_size)
                                                        : 20'h00000;
            end
        end
    end

    // wait holds later commands until the window is met
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            waiting <= 1'b0;
        end else if (take && cmd == laser_tol_pkg::cmd_wait && !win_settled) begin
            waiting <= 1'b1;
        end else if (win_settled) begin
            waiting <= 1'b0;
        end
    end

    // a completion query taken early is answered once the window is met
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pending_opc <= 1'b0;
        end else if (take && cmd == laser_tol_pkg::cmd_opc_query && !win_settled) begin
            pending_opc <= 1'b1;
        end else if (win_settled) begin
            pending_opc <= 1'b0;
        end
    end

    // busy rises on the same edge as the hold, so the host sees a
    // refusal before its next strobe instead of one edge too late
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmd_busy <= 1'b0;
        end else begin
            cmd_busy <= (waiting || pending_opc ||
                (take && cmd == laser_tol_pkg::cmd_wait) ||
                (take && cmd == laser_tol_pkg::cmd_opc_query)) && !win_settled;
        end
    end

    // query replies, one cycle after the command is taken
    // reply_a holds until the next reply or an early completion query; reply_valid pulses,
    // and reply_b is cleared each cycle so a stale window never rides along
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reply_valid <= 1'b0;
            reply_a <= 20'h00000;
            reply_b <= 20'h00000;
        end else begin
            reply_valid <= 1'b0;
            reply_b <= 20'h00000;
            if (pending_opc && win_settled) begin
                reply_valid <= 1'b1;
                reply_a <= 20'h00001;
            end else if (take) begin
                reply_valid <= 1'b1;
                unique case (cmd)
                    laser_tol_pkg::cmd_out_query: reply_a <= {19'h00000, output_on};
                    laser_tol_pkg::cmd_range_query: reply_a <= {16'h0000, range_code};
                    laser_tol_pkg::cmd_ldi_query: reply_a <= current_setpoint;
                    laser_tol_pkg::cmd_mdi_query: reply_a <= monitor_photo_current_setpoint;
                    laser_tol_pkg::cmd_mdp_query: reply_a <= monitor_photo_power_setpoint;
                    laser_tol_pkg::cmd_step_query: reply_a <= 20'(step_size);
                    laser_tol_pkg::cmd_tol_query: begin
                        reply_a <= 20'(band);
                        reply_b <= 20'(window_ms);
                    end
                    laser_tol_pkg::cmd_opc_query: begin
                        reply_valid <= win_settled;
                        reply_a <= 20'h00001;
                    end
                    default: reply_valid <= 1'b0;
                endcase
            end
        end
    end
endmodule // laser_setpoint_tolerance_cmd

// ### test/laser_tol_chk.sv
`timescale 1ns/10ps
// port-level watch on replies, range guard and tolerance flags
module laser_tol_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic output_on,
    input wire logic [19:0] current_setpoint,
    input wire logic [19:0] monitor_photo_current_setpoint,
    input wire logic [19:0] monitor_photo_power_setpoint,
    input wire logic cmd_busy,
    input wire logic reply_valid,
    input wire logic [19:0] reply_a,
    input wire logic error_valid,
    input wire logic [9:0] error_code,
    input wire logic [3:0] range_code,
    input wire logic settled,
    input wire logic tol_event
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic take;
    // a strobe during a hold is dropped, so only these count
    assign take = cmd_valid && !cmd_busy;
    a_out_state: assert property (take && cmd_code == 4'h0 |=>
        reply_valid && reply_a == {19'h00000, $past(output_on)}) else $error("output reply");
    a_range_busy: assert property (take && cmd_code == 4'h1 && output_on |=>
        error_valid && error_code == 10'h203 && $stable(range_code)) else $error("range guard");
    a_range_echo: assert property (take && cmd_code == 4'h2 |=>
        reply_valid && reply_a == {16'h0000, $past(range_code)}) else $error("range reply");
    a_ldi_reply: assert property (take && cmd_code == 4'h3 |=>
        reply_valid && reply_a == $past(current_setpoint)) else $error("current reply");
    a_mdi_reply: assert property (take && cmd_code == 4'h4 |=>
        reply_a == $past(monitor_photo_current_setpoint)) else $error("monitor reply");
    a_mdp_reply: assert property (take && cmd_code == 4'h5 |=>
        reply_a == $past(monitor_photo_power_setpoint)) else $error("power reply");
    a_settle_delay: assert property ($rose(output_on) |=> !settled [*3])
        else $error("settled too early");
    a_wait_holds: assert property (take && cmd_code == 4'hC && !settled && output_on |=>
        cmd_busy) else $error("wait not held");
    a_event_flag: assert property ($rose(settled) |-> ##[0:2] tol_event)
        else $error("no tolerance event");
endmodule // laser_tol_chk

// ### test/laser_host.sv
`timescale 1ns/10ps
// remote host: one command at a time, strobe held until taken
module laser_host (
    input wire logic clock,
    input wire logic cmd_busy,
    output logic cmd_valid,
    output logic [3:0] cmd_code,
    output logic [19:0] cmd_arg_a,
    output logic [19:0] cmd_arg_b
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_arg_a = 20'h00000;
        cmd_arg_b = 20'h00000;
    end
    // arguments are inverted once released so a stale value never matches
    task automatic send(input logic [3:0] code, input logic [19:0] a, input logic [19:0] b);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_arg_a = a;
        cmd_arg_b = b;
        // busy only moves on edges, so its value now is what the next edge sees
        while (cmd_busy === 1'b1 && n < 400) begin
            n++;
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1;
        cmd_valid = 1'b0;
        cmd_arg_a = ~a;
        cmd_arg_b = ~b;
    endtask
endmodule // laser_host

// ### test/test_laser_setpoint_tolerance_cmd.sv
`timescale 1ns/10ps
// drives commands and analog stand-ins, compares replies with the rules
module test_laser_setpoint_tolerance_cmd;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic output_on = 1'b0;
    logic event_clear = 1'b0;
    logic [1:0] laser_mode = 2'h0;
    logic [15:0] monitor_responsivity_alias = 16'h0000;
    logic [19:0] current_setpoint = 20'h00000;
    logic [19:0] monitor_photo_current_setpoint = 20'h00000;
    logic [19:0] monitor_photo_power_setpoint = 20'h00000;
    logic [19:0] measured_current = 20'h00000;
    logic [19:0] monitor_photo_current = 20'h00000;
    logic [19:0] monitor_photo_power = 20'h00000;
    logic cmd_valid, cmd_busy, reply_valid, error_valid, step_write, settled, tol_event;
    logic [3:0] cmd_code, range_code;
    logic [19:0] cmd_arg_a, cmd_arg_b, reply_a, reply_b, step_value;
    logic [9:0] error_code;
    logic [31:0] seed = 32'h0000002E;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #12.5 clock = ~clock;
    // one millisecond shortened to 4 cycles to keep windows brief
    laser_setpoint_tolerance_cmd #(.ms_cycles(4)) dut (.clock, .sys_rst, .cmd_valid, .cmd_code,
        .cmd_arg_a, .cmd_arg_b, .output_on, .laser_mode, .monitor_responsivity_alias,
        .current_setpoint, .monitor_photo_current_setpoint, .monitor_photo_power_setpoint,
        .measured_current, .monitor_photo_current, .monitor_photo_power, .event_clear,
        .cmd_busy, .reply_valid, .reply_a, .reply_b, .error_valid, .error_code, .range_code,
        .step_write, .step_value, .settled, .tol_event);
    laser_host host (.clock, .cmd_busy, .cmd_valid, .cmd_code, .cmd_arg_a, .cmd_arg_b);
    function automatic logic [19:0] rnd(input int lo, input int span);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return 20'(lo + seed % span);
    endfunction
    // the set point a step acts on follows mode and calibration
    function automatic logic [19:0] base_point();
        if (laser_mode != 2'h3) return current_setpoint;
        if (monitor_responsivity_alias == 16'h0000) return monitor_photo_current_setpoint;
        return monitor_photo_power_setpoint;
    endfunction
    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pulses stand one cycle, so look just after every edge
    task automatic await(input int sel, input int lim);
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            hit = sel == 0 ? reply_valid === 1'b1 : sel == 1 ? step_write === 1'b1 : error_valid === 1'b1;
            if (!hit) begin
                @(posedge clock);
                #1;
                n++;
            end
        end
        check("pulse", 20'h00001, {19'h00000, hit});
    endtask
    task automatic query(input logic [3:0] code, input logic [19:0] ea, input string what);
        host.send(code, 20'h00000, 20'h00000);
        await(0, 4);
        check(what, ea, reply_a);
    endtask
    task automatic cycles(input int lim, output int n);
        n = 0;
        while (settled !== 1'b1 && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // the sequence needs about 200 cycles
    initial begin
        #(25 * 20000);
        n_mismatch++;
        results();
    end
    initial begin
        logic [19:0] st;
        int n;
        repeat (4) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        check("reset range", 20'h00005, {16'h0000, range_code});
        query(4'hB, 20'h00064, "band");
        check("window", 20'h01388, reply_b);
        $display("test defaults done");
        for (n = 0; n < 2; n++) begin
            output_on = n[0];
            query(4'h0, 20'(n), "output");
        end
        output_on = 1'b0;
        host.send(4'h1, 20'h00001, 20'h00000);
        query(4'h2, 20'h00001, "range b");
        host.send(4'h1, 20'h00003, 20'h00000);
        query(4'h2, 20'h00001, "bad code");
        host.send(4'h1, 20'h00005, 20'h00000);
        query(4'h2, 20'h00005, "range a");
        output_on = 1'b1;
        host.send(4'h1, 20'h00001, 20'h00000);
        await(2, 4);
        check("error", 20'h00203, {10'h000, error_code});
        query(4'h2, 20'h00005, "range kept");
        $display("test range done");
        for (n = 0; n < 4; n++) begin
            laser_mode = {1'b0, n[0]};
            current_setpoint = rnd(10000, 500000);
            monitor_photo_current_setpoint = rnd(10000, 500000);
            monitor_photo_power_setpoint = rnd(10000, 500000);
            query(4'h3, current_setpoint, "ldi");
            query(4'h4, monitor_photo_current_setpoint, "mdi");
            query(4'h5, monitor_photo_power_setpoint, "mdp");
        end
        for (n = 0; n < 3; n++) begin
            st = n == 0 ? 20'h00001 : n == 1 ? 20'h0270F : rnd(1, 9999);
            host.send(4'h6, st, 20'h00000);
            query(4'h7, st, "step");
        end
        host.send(4'h6, 20'h00000, 20'h00000);
        host.send(4'h6, 20'h02710, 20'h00000);
        query(4'h7, st, "step kept");
        for (n = 0; n < 4; n++) begin
            laser_mode = n < 2 ? n[1:0] : 2'h3;
            monitor_responsivity_alias = n == 3 ? 16'(rnd(1, 60000)) : 16'h0000;
            host.send(4'h8, 20'h00000, 20'h00000);
            await(1, 4);
            check("inc", base_point() + st, step_value);
            host.send(4'h9, 20'h00000, 20'h00000);
            await(1, 4);
            check("dec", base_point() - st, step_value);
        end
        $display("test step done");
        laser_mode = 2'h0;
        output_on = 1'b0;
        current_setpoint = 20'h01000;
        measured_current = 20'h01000;
        host.send(4'hA, 20'h00001, 20'h00001);
        query(4'hB, 20'h00001, "band set");
        check("window set", 20'h00001, reply_b);
        output_on = 1'b1;
        cycles(40, n);
        check("settle time", 20'h00001, {19'h00000, n >= 4 && settled === 1'b1});
        check("event", 20'h00001, {19'h00000, tol_event});
        event_clear = 1'b1;
        @(posedge clock);
        #1;
        event_clear = 1'b0;
        check("event cleared", 20'h00000, {19'h00000, tol_event});
        host.send(4'hA, 20'h00001, 20'h00003);
        current_setpoint = 20'h02000;
        host.send(4'hD, 20'h00000, 20'h00000);
        repeat (3) @(posedge clock);
        #1;
        measured_current = 20'h02000;
        await(0, 80);
        check("opc held", 20'h00001, {19'h00000, settled});
        check("opc reply", 20'h00001, reply_a);
        measured_current = 20'h02005;
        @(posedge clock);
        #1;
        measured_current = 20'h02000;
        repeat (2) @(posedge clock);
        #1;
        check("restart drop", 20'h00000, {19'h00000, settled});
        cycles(60, n);
        check("restart", 20'h00001, {19'h00000, n >= 12 && settled === 1'b1});
        $display("test window done");
        laser_mode = 2'h3;
        monitor_responsivity_alias = 16'h0000;
        measured_current = 20'h00000;
        monitor_photo_current_setpoint = 20'h003E8;
        monitor_photo_current = 20'h00424;
        // let settled fall after the mode change so the wait meets an open window
        @(posedge clock);
        #1;
        host.send(4'hC, 20'h00000, 20'h00000);
        check("wait busy", 20'h00001, {19'h00000, cmd_busy});
        repeat (30) @(posedge clock);
        #1;
        check("outside 50", 20'h00000, {19'h00000, settled});
        monitor_photo_current = 20'h00410;
        cycles(60, n);
        check("inside 50", 20'h00001, {19'h00000, settled});
        $display("test power band done");
        results();
    end
endmodule // test_laser_setpoint_tolerance_cmd
bind laser_setpoint_tolerance_cmd laser_tol_chk chk (.clock, .sys_rst, .cmd_valid, .cmd_code,
    .output_on, .current_setpoint, .monitor_photo_current_setpoint,
    .monitor_photo_power_setpoint, .cmd_busy, .reply_valid, .reply_a, .error_valid,
    .error_code, .range_code, .settled, .tol_event);
